/* File: rtl/eoa_pkg.sv */
// shared constants and carrier types for the e2 orderwire adaptation block
package eoa_pkg;

    // ==========================================================
    // clocking and rates
    localparam int unsigned CLK_HZ = 200_000_000;
    localparam int unsigned OW_RATE_BPS = 64_000;
    // playout bit period in clk cycles (exact: 3125, so 0 ppm vs clk)
    localparam int unsigned OW_BIT_CYCLES = CLK_HZ / OW_RATE_BPS;
    localparam logic [11:0] OW_BIT_LAST = 12'(OW_BIT_CYCLES - 1);
    localparam logic [11:0] OW_BIT_HALF = 12'(OW_BIT_CYCLES / 2);

    // ==========================================================
    // frame position of the e2 byte, counted in byte clocks after frame start
    localparam logic [15:0] E2_BYTE_INDEX = 16'h0012;
    localparam logic [15:0] BYTE_COUNT_RESET = 16'h0000;

    // ==========================================================
    // source slip buffer
    localparam int unsigned WANDER_NS = 18_000;
    localparam int unsigned OW_BIT_NS = 1_000_000_000 / OW_RATE_BPS;
    // octets needed to cover the wander, rounded up
    localparam int unsigned WANDER_OCTETS = (WANDER_NS + 8 * OW_BIT_NS - 1) / (8 * OW_BIT_NS);
    localparam int unsigned BUF_DEPTH = 4;
    localparam int unsigned BUF_AW = 2;
    localparam logic [BUF_AW:0] FILL_LOW = 3'h1;
    localparam logic [BUF_AW:0] FILL_HIGH = 3'h3;
    localparam logic [BUF_AW-1:0] WR_PTR_RESET = 2'h2;
    localparam logic [BUF_AW-1:0] RD_PTR_RESET = 2'h0;
    localparam logic [BUF_AW:0] FILL_RESET = 3'h2;
    localparam logic [7:0] ALL_ONES_OCTET = 8'hff;
    localparam logic [2:0] BIT_LAST = 3'h7;

    // ==========================================================
    // pin groups
    typedef struct packed {
        logic data;
        logic clock;
        logic octet_start;
    } eoa_ow_in_type;

    typedef struct packed {
        logic [7:0] data;
        logic clock;
        logic frame_start;
        logic trail_fail;
    } eoa_sec_in_type;

    typedef struct packed {
        logic clock;
        logic frame_start;
    } eoa_line_in_type;

    typedef enum logic [2:0] {
        SLIP_NONE = 3'b001,
        SLIP_POS = 3'b010,
        SLIP_NEG = 3'b100
    } eoa_slip_type;

endpackage : eoa_pkg

/* File: rtl/eoa_sync.sv */
// two flip-flop synchroniser for a group of pin inputs
module eoa_sync
    import eoa_pkg::*;
#(
    parameter int unsigned WIDTH = 1
)
(
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // asynchronous group in, synchronised group out
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] meta_reg;

    // first stage feeds only the second stage
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            meta_reg <= '0;
            sync_out <= '0;
        end
        else
        begin
            meta_reg <= async_in;
            sync_out <= meta_reg;
        end
    end

endmodule : eoa_sync

/* File: rtl/eoa_top.sv */
// e2 orderwire adaptation: source slip buffer and sink latch/playout
// ==========================================================
// Notes on behaviour
// - source places the 64 kbit/s octet orderwire stream into each frame's e2 byte
// - source writes incoming orderwire octets into a slip buffer on the orderwire clock
// - source reads octets on the line clock at the e2 frame position
// - positive slip cancels reading of one whole octet, once
// - negative slip outputs the same whole octet a second time, once
// - slip buffer absorbs at least 18 us of wander without errors
// - sink extracts the e2 octet from each received frame
// - sink latches each extracted octet into a store on the receive section clock
// - sink shifts the eight stored bits out on a nominal 64 kHz clock
// - trail fail raises server fail and all-ones output within 1 ms
// - trail fail clearing restores extracted data within 1 ms
module eoa_top
    import eoa_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // orderwire source pins
    input wire eoa_ow_in_type ow_in,
    // transmit line timing
    input wire eoa_line_in_type line_in,
    // receive section overhead
    input wire eoa_sec_in_type sec_in,
    // e2 octet towards the transmit framer
    output logic [7:0] section_data_out,
    // orderwire sink pins
    output logic orderwire_data_out,
    output logic orderwire_clock_out,
    output logic orderwire_octet_mark,
    output logic orderwire_server_fail
);

    // ==========================================================
    // reset release and pin synchronisers
    logic [1:0] rst_pipe_reg;
    logic rst_n;
    eoa_ow_in_type ow_s;
    eoa_line_in_type line_s;
    eoa_sec_in_type sec_s;
    eoa_ow_in_type ow_d_reg;
    eoa_line_in_type line_d_reg;
    eoa_sec_in_type sec_d_reg;

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
            rst_pipe_reg <= 2'h0;
        else
            rst_pipe_reg <= {rst_pipe_reg[0], 1'b1};
    end
    assign rst_n = rst_pipe_reg[1];

    eoa_sync #(.WIDTH($bits(eoa_ow_in_type))) u_sync_ow (
        .clk(clk), .rst_n(rst_n), .async_in(ow_in), .sync_out(ow_s));
    eoa_sync #(.WIDTH($bits(eoa_line_in_type))) u_sync_line (
        .clk(clk), .rst_n(rst_n), .async_in(line_in), .sync_out(line_s));
    eoa_sync #(.WIDTH($bits(eoa_sec_in_type))) u_sync_sec (
        .clk(clk), .rst_n(rst_n), .async_in(sec_in), .sync_out(sec_s));

    // delayed copies of synchronised levels for edge detection
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            ow_d_reg <= '0;
            line_d_reg <= '0;
            sec_d_reg <= '0;
        end
        else
        begin
            ow_d_reg <= ow_s;
            line_d_reg <= line_s;
            sec_d_reg <= sec_s;
        end
    end

    logic ow_rise;
    logic line_rise;
    logic sec_rise;
    assign ow_rise = ow_s.clock && !ow_d_reg.clock;
    assign line_rise = line_s.clock && !line_d_reg.clock;
    assign sec_rise = sec_s.clock && !sec_d_reg.clock;

    // byte position counter shared by both halves
    function automatic logic [15:0] next_pos(input logic [15:0] pos, input logic fs);
        next_pos = fs ? BYTE_COUNT_RESET : 16'(pos + 16'h0001);
    endfunction : next_pos

    // ==========================================================
    // source: octet assembly on the orderwire clock
    logic [7:0] ow_shift_reg;
    logic [2:0] ow_bit_reg;
    logic ow_octet_done;

    // octet_start realigns the bit count so slips always cover whole octets
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            ow_shift_reg <= ALL_ONES_OCTET;
            ow_bit_reg <= 3'h0;
        end
        else if (ow_rise)
        begin
            ow_shift_reg <= {ow_shift_reg[6:0], ow_s.data};
            ow_bit_reg <= ow_s.octet_start ? 3'h1 : 3'(ow_bit_reg + 3'h1);
        end
    end
    assign ow_octet_done = ow_rise && (ow_s.octet_start ? 1'b0 : (ow_bit_reg == BIT_LAST));

    // ==========================================================
    // source: slip buffer and read decision
    logic [7:0] buf_mem [BUF_DEPTH];
    logic [BUF_AW-1:0] wr_ptr_reg;
    logic [BUF_AW-1:0] rd_ptr_reg;
    logic [BUF_AW:0] fill_reg;
    logic [15:0] tx_pos_reg;
    logic tx_read;
    logic do_write;
    eoa_slip_type slip_sel;

    assign tx_read = line_rise && (next_pos(tx_pos_reg, line_s.frame_start) == E2_BYTE_INDEX);

    // slip chosen only at the read moment, from the fill level
    // a duplicate cannot drain the store, so it is only used near underflow
    always_comb
    begin
        if (fill_reg <= FILL_LOW)
            slip_sel = SLIP_NEG;
        else if (fill_reg >= FILL_HIGH)
            slip_sel = SLIP_POS;
        else
            slip_sel = SLIP_NONE;
    end

    // a write to a full store is blocked; the skipping slip keeps that from happening
    assign do_write = ow_octet_done && (fill_reg != 3'(BUF_DEPTH));

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            tx_pos_reg <= BYTE_COUNT_RESET;
        else if (line_rise)
            tx_pos_reg <= next_pos(tx_pos_reg, line_s.frame_start);
    end

    // store written per completed octet
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            for (int i = 0; i < BUF_DEPTH; i++)
                buf_mem[i] <= ALL_ONES_OCTET;
            wr_ptr_reg <= WR_PTR_RESET;
        end
        else if (do_write)
        begin
            // the eighth bit arrives on this same edge, so it is merged in here
            buf_mem[wr_ptr_reg] <= {ow_shift_reg[6:0], ow_s.data};
            wr_ptr_reg <= 2'(wr_ptr_reg + 2'h1);
        end
    end

    // read side: one octet per frame, with whole-octet slips
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rd_ptr_reg <= RD_PTR_RESET;
            section_data_out <= ALL_ONES_OCTET;
        end
        else if (tx_read)
        begin
            unique case (slip_sel)
                SLIP_NEG:
                    rd_ptr_reg <= rd_ptr_reg; // no read, e2 sends the last octet again
                SLIP_POS:
                begin
                    section_data_out <= buf_mem[rd_ptr_reg];
                    rd_ptr_reg <= 2'(rd_ptr_reg + 2'h2); // reading of the next whole octet cancelled
                end
                SLIP_NONE:
                begin
                    section_data_out <= buf_mem[rd_ptr_reg];
                    rd_ptr_reg <= 2'(rd_ptr_reg + 2'h1);
                end
            endcase
        end
    end

    // fill level tracks both pointers in one clock domain
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            fill_reg <= FILL_RESET;
        else
        begin
            logic [BUF_AW:0] dec;
            dec = 3'h0;
            if (tx_read)
                dec = (slip_sel == SLIP_NEG) ? 3'h0 : ((slip_sel == SLIP_POS) ? 3'h2 : 3'h1);
            fill_reg <= 3'(fill_reg + {2'h0, do_write} - dec);
        end
    end

    // ==========================================================
    // sink: e2 extraction into the data store
    logic [15:0] rx_pos_reg;
    logic [7:0] rx_store_reg;

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rx_pos_reg <= BYTE_COUNT_RESET;
            rx_store_reg <= ALL_ONES_OCTET;
        end
        else if (sec_rise)
        begin
            rx_pos_reg <= next_pos(rx_pos_reg, sec_s.frame_start);
            if (next_pos(rx_pos_reg, sec_s.frame_start) == E2_BYTE_INDEX)
                rx_store_reg <= sec_s.data;
        end
    end

    // ==========================================================
    // sink: 64 kHz playout and trail fail handling
    logic [11:0] bit_cnt_reg;
    logic [2:0] out_bit_reg;
    logic [7:0] out_shift_reg;
    logic bit_tick;

    // divided from clk rather than the line clock: exact 64 kbit/s, no line-clock gaps
    always_ff @(posedge clk or negedge rst_n)
    begin
        // starting mid bit keeps the clock low until a full first bit, no short pulse after reset
        if (!rst_n)
            bit_cnt_reg <= OW_BIT_HALF;
        else
            bit_cnt_reg <= (bit_cnt_reg == OW_BIT_LAST) ? 12'h000 : 12'(bit_cnt_reg + 12'h001);
    end
    assign bit_tick = (bit_cnt_reg == OW_BIT_LAST);

    // octet loaded at each octet boundary, then shifted msb first
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            out_bit_reg <= 3'h0;
            out_shift_reg <= ALL_ONES_OCTET;
            orderwire_data_out <= 1'b1;
            orderwire_octet_mark <= 1'b0;
        end
        else if (bit_tick)
        begin
            out_bit_reg <= 3'(out_bit_reg + 3'h1);
            orderwire_octet_mark <= (out_bit_reg == 3'h0);
            if (out_bit_reg == 3'h0)
            begin
                out_shift_reg <= {rx_store_reg[6:0], 1'b0};
                orderwire_data_out <= sec_s.trail_fail | rx_store_reg[7];
            end
            else
            begin
                out_shift_reg <= {out_shift_reg[6:0], 1'b0};
                orderwire_data_out <= sec_s.trail_fail | out_shift_reg[7];
            end
        end
    end

    // clock out: high for the first half of each bit, data changes on its rising edge
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            orderwire_clock_out <= 1'b0;
        else
            orderwire_clock_out <= (bit_cnt_reg == OW_BIT_LAST) || (bit_cnt_reg < OW_BIT_HALF - 12'h001);
    end

    // server fail follows the synchronised trail fail level
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            orderwire_server_fail <= 1'b0;
        else
            orderwire_server_fail <= sec_s.trail_fail;
    end

endmodule : eoa_top

/* File: test/eoa_far_end.sv */
// behavioural far end: framer timing, received e2 bytes, orderwire unit
module eoa_far_end
    import eoa_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // bench controls
    input wire logic ow_run,
    input wire logic [7:0] ow_octet,
    input wire logic [7:0] rx_e2,
    input wire logic rx_fail,
    // pins towards the block
    output eoa_ow_in_type ow_in,
    output eoa_line_in_type line_in,
    output eoa_sec_in_type sec_in
);
    logic [6:0] fr_reg;
    logic [5:0] ow_reg;
    logic [4:0] pos;
    logic busy;

    // ====
    // 20 bytes of 4 clk a frame; orderwire stops only at an octet boundary
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
            {fr_reg, ow_reg} <= '0;
        else
        begin
            fr_reg <= (fr_reg == 7'h4f) ? 7'h00 : fr_reg + 7'h01;
            ow_reg <= busy ? ow_reg + 6'h01 : ow_reg;
        end
    end

    // byte clock high in the first half of each byte, shared by both directions
    assign pos = fr_reg[6:2];
    assign line_in = '{!fr_reg[1], pos == 5'h00};
    // bytes other than e2 change every byte so a wrong position shows
    assign sec_in = '{({11'h000, pos} == E2_BYTE_INDEX) ? rx_e2 : {pos, 3'h5}, !fr_reg[1], pos == 5'h00, rx_fail};
    // msb first, clock rising mid bit; when idle the clock stands still low
    assign busy = ow_run || ow_reg != 6'h00;
    assign ow_in = '{busy ? ow_octet[~ow_reg[5:3]] : !ow_octet[0], ow_reg[2], ow_reg[5:3] == 3'h0};
endmodule : eoa_far_end

/* File: test/eoa_monitor.sv */
// port checker for the e2 orderwire adaptation block
module eoa_monitor
    import eoa_pkg::*;
(
    // clock and reset
    input logic clk,
    input logic rst_b,
    // pins in
    input eoa_line_in_type line_in,
    input eoa_sec_in_type sec_in,
    // pins out
    input logic [7:0] section_data_out,
    input logic orderwire_data_out,
    input logic orderwire_clock_out,
    input logic orderwire_octet_mark,
    input logic orderwire_server_fail
);
    logic [11:0] cyc_reg;
    logic [2:0] bit_reg;
    logic [3:0] seen_reg;
    logic rise;
    logic mrise;

    // ====
    // bit timing helpers
    assign rise = orderwire_clock_out && !seen_reg[0];
    assign mrise = orderwire_octet_mark && !seen_reg[1];

    // counters stand in for repetitions far beyond eight cycles
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
            {cyc_reg, bit_reg, seen_reg} <= '0;
        else
        begin
            cyc_reg <= rise ? 12'h000 : cyc_reg + 12'h001;
            bit_reg <= mrise ? 3'h0 : bit_reg + {2'h0, rise};
            seen_reg <= {seen_reg[3] | mrise, seen_reg[2] | rise, orderwire_octet_mark, orderwire_clock_out};
        end
    end

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_b);

    // ====
    // assertions
    a_fail_raise: assert property ($rose(sec_in.trail_fail) |-> ##3 orderwire_server_fail)
        else $error("server fail late");
    a_fail_clear: assert property ($fell(sec_in.trail_fail) |-> ##3 !orderwire_server_fail)
        else $error("server fail stuck");
    a_ones_out: assert property (rise && orderwire_server_fail && $past(orderwire_server_fail) |-> orderwire_data_out)
        else $error("ones missing");
    a_bit_period: assert property (rise && seen_reg[2] |-> cyc_reg == OW_BIT_LAST)
        else $error("bit period wrong");
    a_bit_hold: assert property (!rise |-> $stable(orderwire_data_out))
        else $error("data moved mid bit");
    a_mark_start: assert property ($rose(orderwire_octet_mark) |-> rise)
        else $error("mark off boundary");
    a_octet_len: assert property (mrise && seen_reg[3] |-> bit_reg == 3'h7)
        else $error("octet not eight bits");
    a_e2_quiet: assert property ($rose(line_in.frame_start) |-> $stable(section_data_out) [*8])
        else $error("e2 moved at frame start");

    // main scenarios
    c_fail: cover property ($rose(orderwire_server_fail));
    c_mark: cover property (mrise && seen_reg[3]);
    c_e2: cover property ($changed(section_data_out));
endmodule : eoa_monitor

bind eoa_top eoa_monitor eoa_monitor_inst (.clk, .rst_b, .line_in, .sec_in, .section_data_out,
    .orderwire_data_out, .orderwire_clock_out, .orderwire_octet_mark, .orderwire_server_fail);

/* File: test/eoa_top_bench.sv */
// self-checking bench for the e2 orderwire adaptation block
module eoa_top_bench
    import eoa_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    // rows: received e2 byte, orderwire octet in, octet played out, e2 octet sent
    localparam logic [31:0] ROWS [2] = '{32'ha55a_a55a, 32'h3c81_3c81};

    logic clk;
    logic rst_b;
    logic ow_run;
    logic [7:0] ow_octet;
    logic [7:0] rx_e2;
    logic rx_fail;
    eoa_ow_in_type ow_in;
    eoa_line_in_type line_in;
    eoa_sec_in_type sec_in;
    logic [7:0] section_data_out;
    logic orderwire_data_out;
    logic orderwire_clock_out;
    logic orderwire_octet_mark;
    logic orderwire_server_fail;
    logic [7:0] got;
    int fails;
    int n_checks;

    eoa_far_end eoa_far_end_inst (.clk, .rst_b, .ow_run, .ow_octet, .rx_e2, .rx_fail, .ow_in, .line_in, .sec_in);
    eoa_top eoa_top_inst (.clk, .rst_b, .ow_in, .line_in, .sec_in, .section_data_out, .orderwire_data_out,
        .orderwire_clock_out, .orderwire_octet_mark, .orderwire_server_fail);

    // ====
    // helpers
    task automatic check(string what, logic [7:0] seen, logic [7:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            fails++;
            $display("FAIL %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : report_and_stop

    // n edges, then let that edge's updates land
    task automatic tick(int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : tick

    // bounded wait for the octet mark to reach a level
    task automatic wait_mark(logic lvl);
        int i;
        for (i = 0; i < 30000 && orderwire_octet_mark !== lvl; i++)
            tick(1);
        if (i == 30000)
        begin
            fails++;
            report_and_stop();
        end
    endtask : wait_mark

    // mid-bit sampling of the next whole octet, msb first
    task automatic take_octet(output logic [7:0] b);
        wait_mark(1'b0);
        wait_mark(1'b1);
        tick(OW_BIT_HALF);
        for (int k = 7; k >= 0; k--)
        begin
            b[k] = orderwire_data_out;
            if (k > 0)
                tick(OW_BIT_CYCLES);
        end
    endtask : take_octet

    // ====
    // clock of 5 ns
    initial
    begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    // ====
    // main sequence
    initial
    begin
        fails = 0;
        n_checks = 0;
        rst_b = 1'b0;
        ow_run = 1'b1;
        ow_octet = ROWS[0][23:16];
        rx_e2 = ROWS[0][31:24];
        rx_fail = 1'b0;
        repeat (20) @(posedge clk);
        rst_b <= 1'b1;
        // next row's inputs go in after the last bit, before the octet boundary
        for (int r = 0; r < 2; r++)
        begin
            take_octet(got);
            check("octet played out", got, ROWS[r][15:8]);
            check("e2 octet sent", section_data_out, ROWS[r][7:0]);
            @(posedge clk);
            ow_octet <= ROWS[1][23:16];
            rx_e2 <= ROWS[1][31:24];
        end
        // trail fail, then recovery at an octet boundary
        rx_fail <= 1'b1;
        tick(4);
        check("server fail", {7'h00, orderwire_server_fail}, 8'h01);
        take_octet(got);
        check("all-ones octet", got, ALL_ONES_OCTET);
        @(posedge clk);
        rx_fail <= 1'b0;
        wait_mark(1'b1);
        tick(OW_BIT_HALF);
        check("data resumed", {7'h00, orderwire_data_out}, {7'h00, ROWS[1][15]});
        check("server fail clear", {7'h00, orderwire_server_fail}, 8'h00);
        // orderwire stopped: underflow must send the last whole octet again
        @(posedge clk);
        ow_run <= 1'b0;
        tick(2000);
        check("octet repeated", section_data_out, ROWS[1][7:0]);
        @(posedge clk);
        rst_b <= 1'b0;
        tick(1);
        check("e2 in reset", section_data_out, ALL_ONES_OCTET);
        check("sink in reset", {4'h0, orderwire_data_out, orderwire_clock_out, orderwire_octet_mark,
            orderwire_server_fail}, 8'h08);
        report_and_stop();
    end
endmodule : eoa_top_bench
